// ===== dprc_board.sv
// board side of the soft reset pin
`timescale 1ns/1ns
module dprc_board(input wire lo, soft_reset_oe, soft_reset_out, output wire soft_reset_in_n);
  // pull-up wins only while nobody pulls low
  assign soft_reset_in_n = !(lo || (soft_reset_oe && !soft_reset_out));
endmodule // dprc_board

// ===== dprc_defines.vh
// constants for the dual pin reset control block
`ifndef DPRC_DEFINES_VH
`define DPRC_DEFINES_VH
`define DPRC_DRIVE_CYCLES 6
`define DPRC_CNT_W 3
`define DPRC_SENSE_CYCLES 3
`define DPRC_SYNC_STAGES 2
`define DPRC_SYNC_INIT 2'h2
`endif

// ===== dprc_props.sv
// checker on the reset control ports
`timescale 1ns/1ns
module dprc_props(input wire clk_sys, rst, hard_reset_in_n, soft_reset_in_n,
  soft_reset_out, soft_reset_oe, por_hold, por_pulse, core_hold, core_reset_pulse, run);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence drv6; soft_reset_oe[*6] ##1 !soft_reset_oe; endsequence
  a_hw_hold: assert property (!hard_reset_in_n |-> ##3 por_hold) else $error("hold");
  a_por_run: assert property (por_pulse |-> $past(por_hold) ##[0:1] run) else $error("por");
  a_soft_hold: assert property (soft_reset_oe |-> core_hold) else $error("core");
  a_pin_low: assert property (soft_reset_oe |-> !soft_reset_out) else $error("pin");
  a_drive_six: assert property (disable iff (rst || por_hold)
    $rose(soft_reset_oe) |-> drv6) else $error("six");
  a_soft_exit: assert property (disable iff (rst || por_hold)
    core_reset_pulse |-> !core_hold ##1 run) else $error("end");
  a_por_spared: assert property (core_reset_pulse |-> !por_hold) else $error("spr");
  a_hw_first: assert property (por_hold |-> !soft_reset_oe) else $error("prio");
endmodule // dprc_props
bind dprc_top dprc_props i_props(.*);

// ===== dprc_top.v
// dual pin reset control: hardware power reset and two-way soft reset pin
`timescale 1ns/1ns
`include "dprc_defines.vh"
module dprc_top #(
  parameter DRIVE_CYCLES = `DPRC_DRIVE_CYCLES, // low-drive cycles per output phase
  parameter SENSE_CYCLES = `DPRC_SENSE_CYCLES, // released cycles per sensing phase
  parameter CNT_W = `DPRC_CNT_W, // phase counter width
  parameter SYNC_STAGES = `DPRC_SYNC_STAGES // flops per pin synchroniser, two or more
) (
  input wire clk_sys, // system clock, 125 MHz
  input wire rst, // asynchronous reset, active high
  input wire hard_reset_in_n, // hardware power reset pin, active low
  input wire soft_reset_in_n, // soft reset pin level as sensed
  output reg soft_reset_out, // soft reset pin output value
  output reg soft_reset_oe, // soft reset pin output enable, high = driving
  output reg por_hold, // power-on domain held in reset
  output reg por_pulse, // power-on reset pulse on hard reset release
  output reg core_hold, // core held in soft reset
  output reg core_reset_pulse, // core reset pulse on soft release
  output reg run // execution enabled
);

  // one-hot phase codes
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_POR = 5'h02;
  localparam [4:0] ST_DRIVE = 5'h04;
  localparam [4:0] ST_SENSE = 5'h08;
  localparam [4:0] ST_SOFT = 5'h10;
  // phases during which the core stays in soft reset
  localparam [4:0] ST_CORE_HELD = ST_POR | ST_DRIVE | ST_SENSE;

  // pin index inside the synchroniser vectors
  localparam PIN_HARD = 0;
  localparam PIN_SOFT = 1;
  localparam PIN_COUNT = 2;
  localparam [PIN_COUNT-1:0] SYNC_INIT = `DPRC_SYNC_INIT;

  // counter end points; CNT_W must hold DRIVE_CYCLES-1 and SENSE_CYCLES-1
  localparam [31:0] DRIVE_LAST_W = DRIVE_CYCLES - 32'h1;
  localparam [31:0] SENSE_LAST_W = SENSE_CYCLES - 32'h1;
  localparam [CNT_W-1:0] DRIVE_LAST = DRIVE_LAST_W[CNT_W-1:0];
  localparam [CNT_W-1:0] SENSE_LAST = SENSE_LAST_W[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'h0}};
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'h0}}, 1'h1};

  wire [PIN_COUNT-1:0] pin_raw;
  wire [PIN_COUNT-1:0] pin_sync;
  wire hard_n;
  wire soft_n;
  wire drive_done;
  wire sense_done;
  reg [4:0] state;
  reg [4:0] next_state;
  reg [CNT_W-1:0] cnt;
  reg [CNT_W-1:0] next_cnt;

  // true when a one-hot code lies inside a mask of phases
  function in_phase;
    input [4:0] code;
    input [4:0] mask;
    begin
      in_phase = |(code & mask);
    end
  endfunction

  // next counter value, wrapping to zero when a phase ends
  function [CNT_W-1:0] count_step;
    input [CNT_W-1:0] value;
    input done;
    begin
      if (done) begin
        count_step = CNT_ZERO;
      end else begin
        count_step = value + CNT_ONE;
      end
    end
  endfunction

  assign pin_raw = {soft_reset_in_n, hard_reset_in_n};

  // only the last stage of each chain feeds the phase logic
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g = g + 1) begin : g_sync
      reg [SYNC_STAGES-1:0] stage;
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          // hard pin starts active, so reset ends through a full power-on pass
          stage <= {SYNC_STAGES{SYNC_INIT[g]}};
        end else begin
          stage <= {stage[SYNC_STAGES-2:0], pin_raw[g]};
        end
      end
      assign pin_sync[g] = stage[SYNC_STAGES-1];
    end
  endgenerate

  assign hard_n = pin_sync[PIN_HARD];
  assign soft_n = pin_sync[PIN_SOFT];
  assign drive_done = (cnt == DRIVE_LAST);
  assign sense_done = (cnt == SENSE_LAST);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_POR;
    end else begin
      state <= next_state;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt <= CNT_ZERO;
    end else begin
      cnt <= next_cnt;
    end
  end

  // hard reset overrides whatever soft reset phase is running
  always @* begin
    next_state = state;
    case (state)
      ST_POR: begin
        if (hard_n) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!soft_n) begin
          next_state = ST_DRIVE;
        end
      end
      ST_DRIVE: begin
        if (drive_done) begin
          next_state = ST_SENSE;
        end
      end
      ST_SENSE: begin
        // released pin needs synchroniser delay plus pull-up settling
        if (sense_done) begin
          if (soft_n) begin
            next_state = ST_SOFT;
          end else begin
            next_state = ST_DRIVE;
          end
        end
      end
      ST_SOFT: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_POR;
      end
    endcase
    if (!hard_n) begin
      next_state = ST_POR;
    end
  end

  // the counter restarts on every phase change
  always @* begin
    next_cnt = CNT_ZERO;
    case (next_state)
      ST_DRIVE: begin
        if (state == ST_DRIVE) begin
          next_cnt = count_step(cnt, drive_done);
        end
      end
      ST_SENSE: begin
        if (state == ST_SENSE) begin
          next_cnt = count_step(cnt, sense_done);
        end
      end
      default: begin
        next_cnt = CNT_ZERO;
      end
    endcase
  end

  // the pad only ever pulls low; the pull-up gives the high level
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      soft_reset_out <= 1'h1;
      soft_reset_oe <= 1'h0;
    end else begin
      soft_reset_out <= 1'h0;
      soft_reset_oe <= in_phase(next_state, ST_DRIVE);
    end
  end

  // power-on domain
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      por_hold <= 1'h1;
      por_pulse <= 1'h0;
    end else begin
      por_hold <= in_phase(next_state, ST_POR);
      por_pulse <= in_phase(state, ST_POR) && !in_phase(next_state, ST_POR);
    end
  end

  // soft reset never touches por_hold, so por, clock and debug logic survive
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      core_hold <= 1'h1;
      core_reset_pulse <= 1'h0;
    end else begin
      core_hold <= in_phase(next_state, ST_CORE_HELD);
      core_reset_pulse <= in_phase(next_state, ST_SOFT);
    end
  end

  // execution runs only in the idle phase
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run <= 1'h0;
    end else begin
      run <= in_phase(next_state, ST_IDLE);
    end
  end
endmodule // dprc_top

// ===== tb_dual_pin_reset_control.sv
// bench for the reset control block
`timescale 1ns/1ns
module tb_dual_pin_reset_control;
  logic clk_sys = 0, rst = 1, hard_reset_in_n = 0, lo = 0, soft_reset_in_n, soft_reset_out;
  logic soft_reset_oe, por_hold, por_pulse, core_hold, core_reset_pulse, run;
  int n_fail = 0, checks_done = 0, k, h, p;
  always #4 clk_sys = ~clk_sys;
  dprc_top i_dut(.*);
  dprc_board i_brd(.*);
  task print_verdict;
    $display("fails %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(logic s, logic e);
    checks_done++;
    if (s !== e) n_fail++;
    if (s !== e) $display("FAIL %0t %h %h", $time, s, e);
  endtask
  // fixed spans only: counts drive cycles and power-on pulses
  task cyc(int n);
    repeat (n) begin
      @(negedge clk_sys);
      k += soft_reset_oe + por_pulse;
      h += core_hold;
      p += core_reset_pulse;
    end
  endtask
  task s_hard;
    hard_reset_in_n = 0;
    cyc(6);
    chk(por_hold, 1);
    hard_reset_in_n = 1;
    k = 0;
    cyc(8);
    chk(k == 1 && run, 1);
  endtask
  task s_soft(int n, int d, int c);
    k = 0;
    h = 0;
    p = 0;
    lo = 1;
    cyc(n);
    lo = 0;
    cyc(40);
    chk(k == d && run, 1);
    chk(h == c, 1);
    chk(p == 1 && !core_hold, 1);
    chk(por_hold, 0);
    chk(soft_reset_out, 0);
  endtask
  task s_prio;
    lo = 1;
    cyc(5);
    hard_reset_in_n = 0;
    cyc(3);
    chk(!soft_reset_oe && por_hold, 1);
  endtask
  initial begin
    cyc(2);
    rst = 0;
    s_hard;
    s_soft(1, 6, 9);
    s_soft(14, 12, 18);
    s_prio;
    print_verdict;
  end
endmodule // tb_dual_pin_reset_control
